// ### dv/tb_top.sv
// Purpose: self-checking bench for the buffered pwm generator
// Assumes: inputs driven at rising edges, strobes sampled at falling edges
// Notes: each setup resets first so no load can race a duty transfer
`timescale 1ns/1ns
module tb_top import bpw_pkg::*; ;
  logic clk = 0, rst = 1, ce = 1, countEnable = 0;
  bpw_cfg_t cfg = '0;
  bpw_duty_load_t dutyLoad = '0;
  logic pwmOutPin, periodMatch, dutyMatch;
  logic [CNT_W-1:0] pwmCounter, dutyCompare;
  int fail_count = 0, total_checks = 0;
  always #25 clk = ~clk;
  bpw_pwm bpw_pwm_i (.clk(clk), .rst(rst), .ce(ce), .countEnable(countEnable), .cfg(cfg),
    .dutyLoad(dutyLoad), .pwmOutPin(pwmOutPin), .pwmCounter(pwmCounter), .dutyCompare(dutyCompare),
    .periodMatch(periodMatch), .dutyMatch(dutyMatch));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for a strobe, then let its effect land one edge later
  task automatic wait_hit(input bit duty);
    int n;
    n = 0;
    while (((duty ? dutyMatch : periodMatch) !== 1'b1) && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("strobe", 16'(n < 40), 16'h0001);
    @(posedge clk);
    #1;
  endtask
  // reset, then load duty directly while the counter is held
  task automatic setup(input logic [CNT_W-1:0] p, input logic [CNT_W-1:0] d, input logic [CNT_W-1:0] b);
    @(posedge clk);
    rst <= 1'b1;
    countEnable <= 1'b0;
    @(posedge clk);
    rst <= 1'b0;
    cfg <= '{p, b};
    dutyLoad <= '{1'b1, d};
    @(posedge clk);
    dutyLoad <= '0;
    countEnable <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_normal();
    setup(16'h0003, 16'h0001, 16'h0002);
    wait_hit(1'b1);
    check("pin", 16'(pwmOutPin), 16'h0000);
    check("duty", dutyCompare, 16'h0002);
    wait_hit(1'b0);
    check("cnt", pwmCounter, 16'h0000);
    check("pin", 16'(pwmOutPin), 16'h0001);
    @(posedge clk);
    #1;
    check("cnt", pwmCounter, 16'h0001);
  endtask
  // both compares equal: clear and transfer together, pin held low until duty drops
  task automatic t_full();
    setup(16'h0003, 16'h0003, 16'h0003);
    wait_hit(1'b1);
    check("cnt", pwmCounter, 16'h0000);
    check("pin", 16'(pwmOutPin), 16'h0000);
    wait_hit(1'b1);
    check("pin", 16'(pwmOutPin), 16'h0000);
    // software reloads the buffer after the hit; the next coincident hit carries it over
    @(posedge clk);
    cfg.duty_buffer <= 16'h0002;
    wait_hit(1'b1);
    check("duty", dutyCompare, 16'h0002);
    check("pin", 16'(pwmOutPin), 16'h0000);
    // duty now below period: the period hit alone brings the pin back high
    wait_hit(1'b0);
    check("pin", 16'(pwmOutPin), 16'h0001);
  endtask
  // duty above period: no further duty strobe, pin stays inactive
  task automatic t_zero();
    int hits;
    hits = 0;
    setup(16'h0003, 16'h0001, 16'h0005);
    wait_hit(1'b1);
    wait_hit(1'b0);
    repeat (10) begin
      @(negedge clk);
      hits += int'(dutyMatch === 1'b1);
    end
    check("hits", 16'(hits), 16'h0000);
    check("pin", 16'(pwmOutPin), 16'h0001);
    check("duty", dutyCompare, 16'h0005);
  endtask
  // clock enable low: all state freezes, matches read zero and a load is refused
  task automatic t_freeze();
    setup(16'h0003, 16'h0001, 16'h0002);
    wait_hit(1'b1);
    @(posedge clk);
    ce <= 1'b0;
    dutyLoad <= '{1'b1, 16'h0007};
    repeat (3) @(posedge clk);
    #1;
    check("cnt", pwmCounter, 16'h0003);
    check("pin", 16'(pwmOutPin), 16'h0000);
    check("duty", dutyCompare, 16'h0002);
    check("pmatch", 16'(periodMatch), 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    dutyLoad <= '0;
    wait_hit(1'b0);
    check("cnt", pwmCounter, 16'h0000);
    check("pin", 16'(pwmOutPin), 16'h0001);
    check("duty", dutyCompare, 16'h0002);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("pin", 16'(pwmOutPin), 16'h0001);
    check("duty", dutyCompare, DUTY_RESET);
    t_normal();
    t_full();
    t_zero();
    t_freeze();
    end_of_test();
  end
  // hang guard, far beyond the seventy or so cycles the scenarios need
  initial begin
    #50000;
    fail_count++;
    end_of_test();
  end
endmodule

// ### verilog/bpw_pkg.sv
// Purpose: shared constants and types for the buffered pwm generator
// Assumes: one timer clock at 20 MHz, 16-bit counter and compare values
// Notes: output pin is active low, inactive high
package bpw_pkg;

  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [CNT_W-1:0] DUTY_RESET = 16'hFFFF;
  localparam logic PIN_INACTIVE = 1'b1;
  localparam logic PIN_ACTIVE = 1'b0;

  // software-side settings that travel together
  typedef struct packed {
    logic [CNT_W-1:0] period_compare;
    logic [CNT_W-1:0] duty_buffer;
  } bpw_cfg_t;

  // direct write of the duty compare, used to leave the 0% state
  typedef struct packed {
    logic load;
    logic [CNT_W-1:0] value;
  } bpw_duty_load_t;

  // one-hot output phase
  typedef enum logic [1:0] {
    PH_INACTIVE = 2'b01,
    PH_ACTIVE = 2'b10
  } bpw_phase_t;

endpackage

// ### verilog/bpw_pwm.sv
// Purpose: buffered pwm generator with period and duty compares
// Assumes: rst synchronous active high; ce low freezes all state
// Notes: duty compare reloads from the buffer only on a duty match
`timescale 1ns/1ns

module bpw_pwm
  import bpw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic countEnable,
  input wire bpw_cfg_t cfg,
  input wire bpw_duty_load_t dutyLoad,
  // waveform and state
  output logic pwmOutPin,
  output logic [CNT_W-1:0] pwmCounter,
  output logic [CNT_W-1:0] dutyCompare,
  output logic periodMatch,
  output logic dutyMatch
);

  // ----------------------------------------------------------------
  // compare logic
  // ----------------------------------------------------------------
  bpw_phase_t phase;
  logic [CNT_W-1:0] next_pwmCounter;

  // matches are looked at every counting cycle; duty above period never hits while the counter is within the period
  assign periodMatch = ce && countEnable && (pwmCounter == cfg.period_compare);
  assign dutyMatch = ce && countEnable && (pwmCounter == dutyCompare);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // period match wins over increment, also when duty matches at once
  always_comb begin
    if (periodMatch) begin
      next_pwmCounter = CNT_RESET;
    end else begin
      next_pwmCounter = pwmCounter + 16'h0001;
    end
  end

  // reset first, then the clock enable and the count enable gate every step
  always_ff @(posedge clk) begin
    if (rst) begin
      pwmCounter <= CNT_RESET;
    end else if (ce && countEnable) begin
      pwmCounter <= next_pwmCounter;
    end
  end

  // ----------------------------------------------------------------
  // duty compare and buffer transfer
  // ----------------------------------------------------------------
  // a match transfer beats a direct load so no buffered value is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      dutyCompare <= DUTY_RESET;
    end else if (dutyMatch) begin
      dutyCompare <= cfg.duty_buffer;
    end else if (ce && dutyLoad.load) begin
      dutyCompare <= dutyLoad.value;
    end
  end

  // ----------------------------------------------------------------
  // output phase
  // ----------------------------------------------------------------
  // with duty equal period both hit; the active level wins, giving 100% duty
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= PH_INACTIVE;
    end else if (dutyMatch) begin
      phase <= PH_ACTIVE;
    end else if (periodMatch) begin
      phase <= PH_INACTIVE;
    end
  end

  // decode the phase to the pin; a corrupt code falls back to the safe inactive level
  always_comb begin
    unique case (phase)
      PH_ACTIVE: pwmOutPin = PIN_ACTIVE;
      PH_INACTIVE: pwmOutPin = PIN_INACTIVE;
      default: pwmOutPin = PIN_INACTIVE;
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // sequences shared by the match checks below
  sequence s_period_hit;
    ce && countEnable && pwmCounter == cfg.period_compare;
  endsequence

  sequence s_duty_hit;
    ce && countEnable && pwmCounter == dutyCompare;
  endsequence

  chk_period_clear: assert property (@(posedge clk) disable iff (rst)
    s_period_hit |=> pwmCounter == CNT_RESET)
    else $error("counter not cleared after period match");

  chk_pin_high: assert property (@(posedge clk) disable iff (rst)
    (s_period_hit and !dutyMatch) |=> pwmOutPin == PIN_INACTIVE)
    else $error("pin not inactive after period match");

  chk_buffer_xfer: assert property (@(posedge clk) disable iff (rst)
    s_duty_hit |=> dutyCompare == $past(cfg.duty_buffer))
    else $error("buffer not transferred on duty match");

  chk_pin_low: assert property (@(posedge clk) disable iff (rst)
    s_duty_hit |=> pwmOutPin == PIN_ACTIVE)
    else $error("pin not active after duty match");

  chk_both_match: assert property (@(posedge clk) disable iff (rst)
    (s_period_hit and s_duty_hit) |=> (pwmCounter == CNT_RESET) && dutyCompare == $past(cfg.duty_buffer))
    else $error("coincident match mishandled");

  chk_no_match: assert property (@(posedge clk) disable iff (rst)
    (ce && countEnable && !dutyMatch && !dutyLoad.load) |=> $stable(dutyCompare))
    else $error("duty compare changed without match");

  chk_count_step: assert property (@(posedge clk) disable iff (rst)
    (ce && countEnable && !periodMatch) |=> pwmCounter == $past(pwmCounter) + 16'h0001)
    else $error("counter did not step by one");

  chk_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(pwmCounter) && $stable(pwmOutPin) && $stable(dutyCompare))
    else $error("state moved while clock enable low");

  // ----------------------------------------------------------------
  // hold, load and reset checks
  // ----------------------------------------------------------------
  // counting cycle without a period hit: the counter may only step
  sequence s_step;
    ce && countEnable && !periodMatch;
  endsequence

  // clock enabled but counting switched off
  sequence s_held;
    ce && !countEnable;
  endsequence

  // direct duty write with no duty transfer competing for the register
  sequence s_plain_load;
    ce && dutyLoad.load && !dutyMatch;
  endsequence

  // a new period starts at zero and the next counting cycle reaches one
  // this also catches a counter that skips zero after the clear
  chk_restart_step: assert property (@(posedge clk) disable iff (rst)
    s_period_hit ##1 s_step |=> pwmCounter == 16'h0001)
    else $error("counter did not restart from zero");

  // only a period hit may bring the counter back to zero; all ones wraps on its own
  chk_clear_source: assert property (@(posedge clk) disable iff (rst)
    (ce && countEnable && pwmCounter != cfg.period_compare && !(&pwmCounter)) |=> pwmCounter != CNT_RESET)
    else $error("counter cleared without period match");

  // 100% duty: the coincident hit must not let the pin go inactive
  // duty priority is what makes this hold, so losing it shows up here first
  chk_full_active: assert property (@(posedge clk) disable iff (rst)
    (s_period_hit and s_duty_hit) |=> pwmOutPin == PIN_ACTIVE)
    else $error("pin went inactive on coincident match");

  // an active pin returns high only on a period hit without a duty hit
  chk_active_hold: assert property (@(posedge clk) disable iff (rst)
    (pwmOutPin == PIN_ACTIVE && !(periodMatch && !dutyMatch)) |=> pwmOutPin == PIN_ACTIVE)
    else $error("pin left active level without period match");

  // an inactive pin goes low only on a duty hit
  chk_inactive_hold: assert property (@(posedge clk) disable iff (rst)
    (pwmOutPin == PIN_INACTIVE && !dutyMatch) |=> pwmOutPin == PIN_INACTIVE)
    else $error("pin left inactive level without duty match");

  // duty above period with the counter in range: no duty hit can occur
  chk_zero_duty: assert property (@(posedge clk) disable iff (rst)
    (ce && countEnable && dutyCompare > cfg.period_compare && pwmCounter <= cfg.period_compare) |-> !dutyMatch)
    else $error("duty match with duty above period");

  // with counting off the counter holds its value
  chk_count_hold: assert property (@(posedge clk) disable iff (rst)
    s_held |=> $stable(pwmCounter))
    else $error("counter moved while counting was off");

  // a direct load lands when no duty transfer competes
  chk_duty_load: assert property (@(posedge clk) disable iff (rst)
    s_plain_load |=> dutyCompare == $past(dutyLoad.value))
    else $error("direct duty load lost");

  // a load presented while the clock enable is low is refused
  // matches read zero then, so no transfer can hide the refusal either
  chk_load_refused: assert property (@(posedge clk) disable iff (rst)
    (!ce && dutyLoad.load) |=> $stable(dutyCompare))
    else $error("duty load taken while clock enable low");

  // the one check that looks through reset, so it carries no disable
  // sync reset must return counter, duty compare and pin to idle
  chk_reset_state: assert property (@(posedge clk)
    rst |=> pwmCounter == CNT_RESET && dutyCompare == DUTY_RESET && pwmOutPin == PIN_INACTIVE)
    else $error("reset state wrong");

  // a flipped phase bit would otherwise decode silently to the inactive level
  chk_phase_onehot: assert property (@(posedge clk) disable iff (rst)
    $onehot(phase))
    else $error("output phase lost its one-hot code");

endmodule
